// [pat_cfg.svh]
// Purpose: offsets, field positions, reset values of the translation block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef PAT_CFG_SVH
`define PAT_CFG_SVH

// apb byte offsets
`define PAT_A_CTRL 8'h00
`define PAT_A_BASE 8'h04
`define PAT_A_INVA 8'h08
`define PAT_A_CMD 8'h0c
`define PAT_A_RES 8'h10

// reset values
`define PAT_CTRL_RST 32'h00000000
`define PAT_BASE_RST 32'h00000000
`define PAT_INVA_RST 32'h00000000

// control and command bits
`define PAT_CTRL_8K 0
`define PAT_CMD_ONE 0
`define PAT_CMD_ALL 1
`define PAT_CMD_NSH 2
`define PAT_INVA_FCODE 0

// result register bits
`define PAT_RES_RES 0
`define PAT_RES_WP 1
`define PAT_RES_SUP 2
`define PAT_RES_DIRTY 3
`define PAT_RES_SHR 4
`define PAT_RES_BERR 5
`define PAT_RES_UTAG0 6
`define PAT_RES_UTAG1 7

// descriptor fields
`define PAT_D_TYPE 1:0
`define PAT_D_W 2
`define PAT_D_M 4
`define PAT_D_S 7
`define PAT_D_UTAG0 8
`define PAT_D_UTAG1 9
`define PAT_D_G 10
`define PAT_D_PA 31:12
`define PAT_D_PTR 31:2
`define PAT_TYPE_INV 2'h0
`define PAT_TYPE_IND 2'h2

`endif

// [pat_desc_decode.sv]
// Purpose: decode one fetched table descriptor
// Assumes: second_lvl high when the word came through an indirect pointer
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "pat_cfg.svh"
module pat_desc_decode (
  // fetched word
  input wire logic [31:0] desc,
  input wire logic second_lvl,
  // decoded view
  output var pat_pkg::pat_desc_t dec
);
  import pat_pkg::*;
  logic [1:0] dtype;
  assign dtype = desc[`PAT_D_TYPE];

  always_comb begin
    dec = '0;
    dec.is_ind = !second_lvl && (dtype == `PAT_TYPE_IND);
    dec.is_inv = (dtype == `PAT_TYPE_INV) || (second_lvl && dtype == `PAT_TYPE_IND);
    dec.is_res = desc[0];
    // pointer only meaningful for indirect words
    dec.ptr = dec.is_ind ? desc[`PAT_D_PTR] : 30'h0;
    dec.pa = desc[`PAT_D_PA];
    dec.wp = desc[`PAT_D_W];
    dec.dirty = desc[`PAT_D_M];
    dec.sup = desc[`PAT_D_S];
    dec.shared = desc[`PAT_D_G];
    dec.user_tag_0 = desc[`PAT_D_UTAG0];
    dec.user_tag_1 = desc[`PAT_D_UTAG1];
  end
endmodule : pat_desc_decode
`default_nettype wire

// [pat_pkg.sv]
// Purpose: types of the translation block
// Assumes: nothing
// Notes: constants live in pat_cfg.svh
package pat_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_HOLD, S_FETCH1, S_FETCH2, S_MARK, S_LOAD
  } pat_state_t;

  typedef struct packed {
    logic valid;
    logic [31:0] la;
    logic sup;
    logic write;
    logic rmw;
  } pat_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pat_mreq_t;

  typedef struct packed {
    logic active;
    logic [15:0] tag;
    logic function_code_bit2;
    logic [19:0] pa;
    logic shared;
    logic dirty;
    logic sup;
    logic wp;
    logic resident;
    logic user_tag_0;
    logic user_tag_1;
  } pat_entry_t;

  typedef struct packed {
    logic is_inv;
    logic is_res;
    logic is_ind;
    logic [29:0] ptr;
    logic [19:0] pa;
    logic wp;
    logic dirty;
    logic sup;
    logic shared;
    logic user_tag_0;
    logic user_tag_1;
  } pat_desc_t;
endpackage : pat_pkg

// [pat_walk_mem.sv]
// Purpose: table memory behind the walk port
// Assumes: one request at a time, held until answered
// Notes: lat slows answers; bad_addr answers with a bus error
`timescale 1ns/10ps
`default_nettype none
module pat_walk_mem (
  // clock
  input wire logic pclk,
  // walk port
  input wire pat_pkg::pat_mreq_t walk_req,
  output logic walk_ack,
  output logic bus_error_ack,
  output logic [31:0] walk_rdata,
  // test controls
  input wire logic [1:0] lat,
  input wire logic [31:0] bad_addr
);
  import pat_pkg::*;
  logic [31:0] mem [0:4095];
  logic [1:0] wait_cnt = 2'd0;
  logic [31:0] last = 32'h0;
  initial begin
    walk_ack = 1'b0;
    bus_error_ack = 1'b0;
    walk_rdata = 32'h0;
  end
  always @(posedge pclk) begin
    walk_ack <= 1'b0;
    bus_error_ack <= 1'b0;
    // released data lines never repeat the last word
    walk_rdata <= ~last;
    // skip the edge after an answer: request is still the old one there
    if (walk_req.req && !walk_ack && !bus_error_ack) begin
      if (wait_cnt < lat) begin
        wait_cnt <= wait_cnt + 2'd1;
      end else begin
        wait_cnt <= 2'd0;
        if (walk_req.addr === bad_addr) begin
          bus_error_ack <= 1'b1;
        end else begin
          walk_ack <= 1'b1;
          walk_rdata <= mem[walk_req.addr[13:2]];
          last <= mem[walk_req.addr[13:2]];
          if (walk_req.we) mem[walk_req.addr[13:2]] <= walk_req.wdata;
        end
      end
    end
  end
endmodule : pat_walk_mem
`default_nettype wire

// [pat_xlat.sv]
// Purpose: translation cache, descriptor walk and dirty-bit update
// Assumes: requester holds req stable until xlat_valid or access_error
// Notes: direct mapped, 16 sets; apb slave with one wait-free answer
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pat_cfg.svh"
module pat_xlat (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory unit request
  input wire pat_pkg::pat_req_t req,
  // cache controller side
  output logic xlat_valid,
  output logic [31:0] xlat_pa,
  output logic page_attr_out_0,
  output logic page_attr_out_1,
  output logic access_error,
  output logic xlat_abort,
  // table walk memory port
  output var pat_pkg::pat_mreq_t walk_req,
  input wire logic walk_ack,
  input wire logic bus_error_ack,
  input wire logic [31:0] walk_rdata
);
  import pat_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pat_state_t st_reg, st_next;
  pat_req_t cur_reg, cur_next;
  pat_entry_t pend_reg, pend_next;
  pat_mreq_t mreq_reg, mreq_next;
  logic [31:0] daddr_reg, daddr_next;
  logic [31:0] xpa_reg, xpa_next;
  logic xv_reg, xv_next, err_reg, err_next, abt_reg, abt_next;
  logic a0_reg, a0_next, a1_reg, a1_next, berr_reg, berr_next;
  pat_entry_t ent_reg [16];
  pat_entry_t ent_next [16];
  logic [31:0] ctrl_reg, ctrl_next, base_reg, base_next, inva_reg, inva_next;
  logic [31:0] prd_reg, prd_next, rdmux;
  logic prdy_reg, prdy_next, perr_reg, perr_next;
  pat_desc_t dec;
  pat_entry_t he;
  logic page8k, hit, store, cur_store, sup_viol, load, mapped, setup, wr;
  logic inv_one, inv_all, inv_nsh;
  logic [3:0] idx, widx, iidx;
  logic [19:0] vpn;
  logic [31:0] first_addr, hit_pa;

  function automatic logic [3:0] set_of(input logic [31:0] la, input logic p8);
    return p8 ? la[16:13] : la[15:12];
  endfunction : set_of

  function automatic logic [31:0] phys(input logic [19:0] pa, input logic [31:0] la,
                                       input logic p8);
    // 8k pages ignore the lowest base bit
    return p8 ? {pa[19:1], la[12:0]} : {pa, la[11:0]};
  endfunction : phys

  assign page8k = ctrl_reg[`PAT_CTRL_8K];
  assign idx = set_of(req.la, page8k);
  assign widx = set_of(cur_reg.la, page8k);
  assign iidx = set_of(inva_reg, page8k);
  assign he = ent_reg[idx];
  // bit 16 is also compared for 8k pages; harmless since it is the index
  assign hit = he.active && he.tag == req.la[31:16] && he.function_code_bit2 == req.sup;
  assign store = req.write || req.rmw;
  assign cur_store = cur_reg.write || cur_reg.rmw;
  assign sup_viol = he.sup && !req.sup;
  assign load = st_reg == S_LOAD;
  assign hit_pa = phys(he.pa, req.la, page8k);
  assign vpn = page8k ? {1'b0, req.la[31:13]} : req.la[31:12];
  assign first_addr = base_reg + {10'h0, vpn, 2'b00};

  pat_desc_decode u_dec (
    .desc(walk_rdata),
    .second_lvl(st_reg == S_FETCH2),
    .dec(dec)
  );

  // lookup and walk sequencer
  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    pend_next = pend_reg;
    mreq_next = mreq_reg;
    daddr_next = daddr_reg;
    xpa_next = xpa_reg;
    a0_next = a0_reg;
    a1_next = a1_reg;
    berr_next = berr_reg;
    xv_next = 1'b0;
    err_next = 1'b0;
    abt_next = 1'b0;
    unique case (st_reg)
      S_IDLE: begin
        if (req.valid) begin
          if (hit && (!he.resident || sup_viol || (store && he.wp))) begin
            err_next = 1'b1;
            st_next = S_HOLD;
          end else if (hit && !(store && !he.dirty)) begin
            xv_next = 1'b1;
            xpa_next = hit_pa;
            a0_next = he.user_tag_0;
            a1_next = he.user_tag_1;
            st_next = S_HOLD;
          end else begin
            // clean store hit walks again so memory sees the dirty bit
            abt_next = 1'b1;
            cur_next = req;
            pend_next = '0;
            pend_next.tag = req.la[31:16];
            pend_next.function_code_bit2 = req.sup;
            berr_next = 1'b0;
            daddr_next = first_addr;
            mreq_next.req = 1'b1;
            mreq_next.we = 1'b0;
            mreq_next.addr = first_addr;
            mreq_next.wdata = 32'h0;
            st_next = S_FETCH1;
          end
        end
      end
      S_HOLD: begin
        // one idle cycle lets the requester drop its request
        st_next = S_IDLE;
      end
      S_FETCH1, S_FETCH2: begin
        if (bus_error_ack) begin
          mreq_next.req = 1'b0;
          berr_next = 1'b1;
          pend_next.resident = 1'b0;
          st_next = S_LOAD;
        end else if (walk_ack) begin
          mreq_next.req = 1'b0;
          if (dec.is_ind) begin
            pend_next.wp = pend_reg.wp || dec.wp;
            daddr_next = {dec.ptr, 2'b00};
            mreq_next.req = 1'b1;
            mreq_next.addr = {dec.ptr, 2'b00};
            st_next = S_FETCH2;
          end else if (dec.is_inv) begin
            pend_next.resident = 1'b0;
            st_next = S_LOAD;
          end else begin
            pend_next.wp = pend_reg.wp || dec.wp;
            pend_next.pa = dec.pa;
            pend_next.shared = dec.shared;
            pend_next.sup = dec.sup;
            pend_next.user_tag_0 = dec.user_tag_0;
            pend_next.user_tag_1 = dec.user_tag_1;
            pend_next.dirty = dec.dirty;
            pend_next.resident = 1'b1;
            st_next = S_LOAD;
            if (cur_store && !dec.dirty && !(pend_reg.wp || dec.wp)
                && !(dec.sup && !cur_reg.sup)) begin
              pend_next.dirty = 1'b1;
              mreq_next.req = 1'b1;
              mreq_next.we = 1'b1;
              mreq_next.wdata = walk_rdata | (32'h1 << `PAT_D_M);
              st_next = S_MARK;
            end
          end
        end
      end
      S_MARK: begin
        if (bus_error_ack) begin
          mreq_next.req = 1'b0;
          berr_next = 1'b1;
          pend_next.resident = 1'b0;
          st_next = S_LOAD;
        end else if (walk_ack) begin
          mreq_next.req = 1'b0;
          mreq_next.we = 1'b0;
          st_next = S_LOAD;
        end
      end
      S_LOAD: begin
        // held request is looked up again next cycle
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      cur_reg <= '0;
      pend_reg <= '0;
      mreq_reg <= '0;
      daddr_reg <= 32'h0;
      xpa_reg <= 32'h0;
      xv_reg <= 1'b0;
      err_reg <= 1'b0;
      abt_reg <= 1'b0;
      a0_reg <= 1'b0;
      a1_reg <= 1'b0;
      berr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      pend_reg <= pend_next;
      mreq_reg <= mreq_next;
      daddr_reg <= daddr_next;
      xpa_reg <= xpa_next;
      xv_reg <= xv_next;
      err_reg <= err_next;
      abt_reg <= abt_next;
      a0_reg <= a0_next;
      a1_reg <= a1_next;
      berr_reg <= berr_next;
    end
  end

  sequence s_miss;
    st_reg == S_IDLE && req.valid && !hit;
  endsequence
  sequence s_mark;
    st_reg == S_MARK && mreq_reg.req;
  endsequence

  a_miss_abort: assert property (s_miss |=> abt_reg && st_reg == S_FETCH1)
    else $error("miss did not abort and walk");
  a_clean_store: assert property (st_reg == S_IDLE && req.valid && hit && he.resident
    && !sup_viol && store && !he.wp && !he.dirty |=> abt_reg && !xv_reg)
    else $error("clean store hit was not walked");
  a_wp_error: assert property (st_reg == S_IDLE && req.valid && hit && store
    && he.wp |=> err_reg && !xv_reg)
    else $error("store to protected entry passed");
  a_sup_error: assert property (st_reg == S_IDLE && req.valid && hit
    && sup_viol |=> err_reg ##1 !err_reg)
    else $error("user access to privileged page passed");
  a_hit_pa: assert property (st_reg == S_IDLE && req.valid && hit && he.resident
    && !sup_viol && !store |=> xv_reg && xpa_reg == $past(hit_pa)
    && a0_reg == $past(he.user_tag_0) && a1_reg == $past(he.user_tag_1))
    else $error("hit gave wrong address or attributes");
  a_ind_follow: assert property (st_reg == S_FETCH1 && walk_ack && !bus_error_ack
    && walk_rdata[1:0] == 2'h2 |=> st_reg == S_FETCH2 && mreq_reg.req
    && mreq_reg.addr == {$past(walk_rdata[31:2]), 2'b00})
    else $error("indirect pointer not followed");
  a_second_ind: assert property (st_reg == S_FETCH2 && walk_ack && !bus_error_ack
    && walk_rdata[1:0] == 2'h2 |=> st_reg == S_LOAD && !pend_reg.resident)
    else $error("second level indirect not invalid");
  a_berr_nonres: assert property ((st_reg == S_FETCH1 || st_reg == S_FETCH2
    || st_reg == S_MARK) && bus_error_ack |=> load && !pend_reg.resident)
    else $error("bus error left entry resident");
  a_mark_write: assert property (s_mark |-> mreq_reg.we
    && mreq_reg.wdata[`PAT_D_M] && mreq_reg.addr == daddr_reg)
    else $error("dirty update write malformed");
  a_wp_accum: assert property (st_reg == S_FETCH2 && pend_reg.wp && walk_ack
    && !bus_error_ack |=> pend_reg.wp)
    else $error("table protection lost");

  // translation cache entries
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      ent_next[i] = ent_reg[i];
      if (inv_all && !(inv_nsh && ent_reg[i].shared)) begin
        ent_next[i].active = 1'b0;
      end
      if (inv_one && !(inv_nsh && ent_reg[i].shared) && 4'(i) == iidx
          && ent_reg[i].tag == inva_reg[31:16]
          && ent_reg[i].function_code_bit2 == inva_reg[`PAT_INVA_FCODE]) begin
        ent_next[i].active = 1'b0;
      end
      // a fresh load wins over a same-cycle invalidate
      if (load && 4'(i) == widx) begin
        ent_next[i] = pend_reg;
        ent_next[i].active = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        ent_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        ent_reg[i] <= ent_next[i];
      end
    end
  end

  a_load_valid: assert property (load |=> ent_reg[$past(widx)].active
    && st_reg == S_IDLE)
    else $error("loaded entry not active");
  a_shared_kept: assert property (inv_all && inv_nsh && ent_reg[0].active
    && ent_reg[0].shared |=> ent_reg[0].active)
    else $error("shared entry invalidated");

  // apb slave, answers in the first access cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && prdy_reg && pwrite && !perr_reg;
  assign mapped = paddr == `PAT_A_CTRL || paddr == `PAT_A_BASE
    || paddr == `PAT_A_INVA || paddr == `PAT_A_CMD || paddr == `PAT_A_RES;
  assign inv_one = wr && paddr == `PAT_A_CMD && pwdata[`PAT_CMD_ONE];
  assign inv_all = wr && paddr == `PAT_A_CMD && pwdata[`PAT_CMD_ALL];
  assign inv_nsh = pwdata[`PAT_CMD_NSH];

  always_comb begin
    rdmux = 32'h0;
    unique case (paddr)
      `PAT_A_CTRL: rdmux = ctrl_reg;
      `PAT_A_BASE: rdmux = base_reg;
      `PAT_A_INVA: rdmux = inva_reg;
      `PAT_A_RES: begin
        rdmux[31:12] = pend_reg.pa;
        rdmux[`PAT_RES_RES] = pend_reg.resident;
        rdmux[`PAT_RES_WP] = pend_reg.wp;
        rdmux[`PAT_RES_SUP] = pend_reg.sup;
        rdmux[`PAT_RES_DIRTY] = pend_reg.dirty;
        rdmux[`PAT_RES_SHR] = pend_reg.shared;
        rdmux[`PAT_RES_BERR] = berr_reg;
        rdmux[`PAT_RES_UTAG0] = pend_reg.user_tag_0;
        rdmux[`PAT_RES_UTAG1] = pend_reg.user_tag_1;
      end
      default: rdmux = 32'h0;
    endcase
  end

  always_comb begin
    prdy_next = setup;
    perr_next = setup && !mapped;
    prd_next = (setup && !pwrite) ? rdmux : 32'h0;
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    inva_next = inva_reg;
    if (wr && paddr == `PAT_A_CTRL) begin
      ctrl_next = {31'h0, pwdata[`PAT_CTRL_8K]};
    end
    if (wr && paddr == `PAT_A_BASE) begin
      base_next = {pwdata[31:2], 2'b00};
    end
    if (wr && paddr == `PAT_A_INVA) begin
      inva_next = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdy_reg <= 1'b0;
      perr_reg <= 1'b0;
      prd_reg <= 32'h0;
      ctrl_reg <= `PAT_CTRL_RST;
      base_reg <= `PAT_BASE_RST;
      inva_reg <= `PAT_INVA_RST;
    end else begin
      prdy_reg <= prdy_next;
      perr_reg <= perr_next;
      prd_reg <= prd_next;
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      inva_reg <= inva_next;
    end
  end

  assign prdata = prd_reg;
  assign pready = prdy_reg;
  assign pslverr = perr_reg;
  assign xlat_valid = xv_reg;
  assign xlat_pa = xpa_reg;
  assign page_attr_out_0 = a0_reg;
  assign page_attr_out_1 = a1_reg;
  assign access_error = err_reg;
  assign xlat_abort = abt_reg;
  assign walk_req = mreq_reg;
endmodule : pat_xlat
`default_nettype wire

// [pat_xlat_bench.sv]
// Purpose: self-checking bench of the translation block
// Assumes: table base 0x1000, descriptors preset in the walk memory
// Notes: drivers queue expectations, one monitor judges responses
`timescale 1ns/10ps
`default_nettype none
`include "pat_cfg.svh"
module pat_xlat_bench;
  import pat_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} pat_apbx_t;
  typedef struct {logic e; logic [31:0] pa; logic [1:0] ua;} pat_xx_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pat_req_t req = '0;
  logic xlat_valid;
  logic [31:0] xlat_pa;
  logic pa0;
  logic pa1;
  logic access_error;
  logic xlat_abort;
  pat_mreq_t walk_req;
  logic walk_ack;
  logic bus_error_ack;
  logic [31:0] walk_rdata;
  logic [1:0] lat = 2'd0;
  logic [31:0] bad_addr = 32'hffffffff;
  logic eight = 1'b0;
  logic [19:0] vp;
  logic [31:0] la;
  logic [31:0] dw;
  logic [31:0] la_s;
  logic [31:0] dw_s;
  logic [11:0] di;
  int error_cnt = 0;
  int num_checks = 0;
  int aborts = 0;
  pat_apbx_t aq[$];
  pat_xx_t tq[$];
  pat_apbx_t ax;
  pat_xx_t tx;
  always #50 pclk = ~pclk;
  pat_xlat dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .xlat_valid(xlat_valid), .xlat_pa(xlat_pa),
    .page_attr_out_0(pa0), .page_attr_out_1(pa1), .access_error(access_error),
    .xlat_abort(xlat_abort), .walk_req(walk_req), .walk_ack(walk_ack),
    .bus_error_ack(bus_error_ack), .walk_rdata(walk_rdata));
  pat_walk_mem mem_u (.pclk(pclk), .walk_req(walk_req), .walk_ack(walk_ack),
    .bus_error_ack(bus_error_ack), .walk_rdata(walk_rdata), .lat(lat),
    .bad_addr(bad_addr));
  task automatic chk(string w, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  always @(posedge pclk) begin
    if (xlat_abort === 1'b1) aborts++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (aq.size() == 0) chk("apb read", 32'h0, 32'h1);
      else begin
        ax = aq.pop_front();
        chk("prdata", ax.v & ax.m, prdata & ax.m);
        chk("pslverr", 32'(ax.e), 32'(pslverr));
      end
    end
    if (xlat_valid === 1'b1 || access_error === 1'b1) begin
      if (tq.size() == 0) chk("response", 32'h0, 32'h1);
      else begin
        tx = tq.pop_front();
        chk("access_error", 32'(tx.e), 32'(access_error));
        if (!tx.e) chk("xlat_pa", tx.pa, xlat_pa);
        if (!tx.e) chk("attr", 32'(tx.ua), 32'({pa1, pa0}));
      end
    end
  end
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [7:0] a, logic [31:0] v, logic [31:0] m, logic e);
    aq.push_back('{v, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // expected address follows the page size in force
  task automatic xl(logic sup, logic wr, logic rmw, logic e, int nab);
    tq.push_back('{e, eight ? {dw[31:13], la[12:0]} : {dw[31:12], la[11:0]}, dw[9:8]});
    aborts = 0;
    @(posedge pclk);
    lat <= 2'($urandom);
    req <= '{1'b1, la, sup, wr, rmw};
    do @(posedge pclk); while (xlat_valid !== 1'b1 && access_error !== 1'b1);
    req.valid <= 1'b0;
    @(posedge pclk);
    chk("aborts", 32'(nab), 32'(aborts));
  endtask : xl
  task automatic pg(logic [3:0] k, logic [11:0] f);
    vp = {10'h0, 6'($urandom), k};
    la = {vp, 12'($urandom)};
    dw = {20'($urandom), f};
    di = 12'h400 + vp[11:0];
    mem_u.mem[di] = dw;
  endtask : pg
  task automatic dirty(logic e);
    chk("dirty", 32'(e), 32'(mem_u.mem[di][4]));
  endtask : dirty
  task automatic fin(string s);
    $display("test %s done", s);
  endtask : fin
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(80393));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PAT_A_CTRL, 32'h0, '1, 1'b0);
    rd(`PAT_A_BASE, 32'h0, '1, 1'b0);
    rd(`PAT_A_INVA, 32'h0, '1, 1'b0);
    rd(`PAT_A_CMD, 32'h0, '1, 1'b0);
    rd(8'h14, 32'h0, '1, 1'b1);
    apb(1'b1, `PAT_A_BASE, 32'h1003);
    rd(`PAT_A_BASE, 32'h1000, '1, 1'b0);
    fin("registers");
    pg(4'd1, 12'h101);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 0);
    xl(1'b1, 1'b0, 1'b0, 1'b0, 1);
    pg(4'd2, 12'h203);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    dirty(1'b0);
    xl(1'b0, 1'b1, 1'b0, 1'b0, 1);
    dirty(1'b1);
    xl(1'b0, 1'b1, 1'b0, 1'b0, 0);
    pg(4'd3, 12'h001);
    xl(1'b0, 1'b0, 1'b1, 1'b0, 1);
    dirty(1'b1);
    fin("dirty marking");
    pg(4'd4, 12'h005);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    xl(1'b0, 1'b1, 1'b0, 1'b1, 0);
    dirty(1'b0);
    pg(4'd5, 12'h081);
    xl(1'b0, 1'b0, 1'b0, 1'b1, 1);
    xl(1'b1, 1'b0, 1'b0, 1'b0, 1);
    pg(4'd6, 12'hffc);
    xl(1'b0, 1'b0, 1'b0, 1'b1, 1);
    rd(`PAT_A_RES, 32'h0, 32'h1, 1'b0);
    fin("protection");
    pg(4'd7, 12'h000);
    mem_u.mem[di] = 32'h2402;
    dw = {20'($urandom), 12'h301};
    mem_u.mem[12'h900] = dw;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    rd(`PAT_A_RES, {dw[31:12], 12'h001}, 32'hfffff001, 1'b0);
    pg(4'd8, 12'h000);
    mem_u.mem[di] = 32'h2406;
    mem_u.mem[12'h901] = 32'h2402;
    xl(1'b0, 1'b0, 1'b0, 1'b1, 1);
    pg(4'd9, 12'h000);
    mem_u.mem[di] = 32'h240e;
    dw = {20'($urandom), 12'h001};
    // pointer bit 2 doubles as the protect bit, so the word is odd
    di = 12'h903;
    mem_u.mem[di] = dw;
    xl(1'b0, 1'b1, 1'b0, 1'b1, 1);
    dirty(1'b0);
    pg(4'd10, 12'h001);
    bad_addr = 32'h1000 + {10'h0, vp, 2'b00};
    xl(1'b0, 1'b0, 1'b0, 1'b1, 1);
    rd(`PAT_A_RES, 32'h20, 32'h21, 1'b0);
    bad_addr = 32'hffffffff;
    fin("walk outcomes");
    pg(4'd1, 12'h001);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    apb(1'b1, `PAT_A_INVA, {la[31:12], 12'h000});
    apb(1'b1, `PAT_A_CMD, 32'h1);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    // set 0 holds the shared entry that the keep check watches
    pg(4'd0, 12'h401);
    la_s = la;
    dw_s = dw;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    pg(4'd12, 12'h001);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    apb(1'b1, `PAT_A_CMD, 32'h6);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    la = la_s;
    dw = dw_s;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 0);
    apb(1'b1, `PAT_A_INVA, {la[31:12], 12'h000});
    apb(1'b1, `PAT_A_CMD, 32'h5);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 0);
    apb(1'b1, `PAT_A_CMD, 32'h2);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    fin("invalidate");
    // stale 4K entries must go once the page size changes
    apb(1'b1, `PAT_A_CTRL, 32'h1);
    apb(1'b1, `PAT_A_CMD, 32'h2);
    eight = 1'b1;
    la = {9'h0, 6'($urandom), 4'd13, 13'($urandom)};
    di = 12'h400 + la[24:13];
    dw = {20'($urandom), 12'h001};
    mem_u.mem[di] = dw;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 1);
    la[12] = ~la[12];
    xl(1'b0, 1'b0, 1'b0, 1'b0, 0);
    fin("large pages");
    complete_run();
  end
  // 44 transfers of under 30 cycles each; fifteen times that
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
endmodule : pat_xlat_bench
`default_nettype wire
